// file: rtl/inverter_param_regs_b_pkg.sv
// Package for the second-half parameter bank of the inverter: register map,
// legal ranges, initialisation values and timing constants.
// Assumes a 16-bit word-addressed host port that reaches the printed offsets.
package inverter_param_regs_b_pkg;

   // Port widths and bank size
   localparam int DW = 16;
   localparam int AW = 16;
   localparam int NREG = 30;

   // Indices into the bank that the control logic looks at directly
   localparam int IDX_CARRIER = 0;
   localparam int IDX_STOP = 1;
   localparam int IDX_SCOPE = 2;
   localparam int IDX_VF_F1 = 3;
   localparam int IDX_VF_F7 = 15;
   localparam int IDX_OV_EN = 17;
   localparam int IDX_OV_LEVEL = 18;
   localparam int IDX_LINK_LOSS = 27;
   localparam int IDX_PROTECT = 28;
   localparam int IDX_TRIGGER = 29;

   // Word addresses, in bank index order
   localparam logic [AW-1:0] REG_ADDR [NREG] = '{
      16'h135C, 16'h135E, 16'h1361,
      16'h1367, 16'h1368, 16'h1369, 16'h136A, 16'h136B, 16'h136C, 16'h136D,
      16'h136E, 16'h136F, 16'h1370, 16'h1371, 16'h1372, 16'h1373, 16'h1374,
      16'h1385, 16'h1386, 16'h1387, 16'h1388, 16'h1389,
      16'h1399, 16'h13A3, 16'h13A4, 16'h13A6, 16'h13A7, 16'h13A8, 16'h13A9,
      16'h13B7};

   // Lower bound of each legal range
   localparam logic [DW-1:0] REG_MIN [NREG] = '{
      16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h014A, 16'h000A, 16'h0000, 16'h0000,
      16'h0001, 16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000};

   // Upper bound; frequency points 1 to 6 take the next point's value instead
   localparam logic [DW-1:0] REG_MAX [NREG] = '{
      16'h0001, 16'h0001, 16'h0001,
      16'h0000, 16'h0BB8, 16'h0000, 16'h0BB8, 16'h0000, 16'h0BB8, 16'h0000,
      16'h0BB8, 16'h0000, 16'h0BB8, 16'h0000, 16'h0BB8, 16'h0190, 16'h0BB8,
      16'h0003, 16'h0186, 16'h0BB8, 16'h01F4, 16'h05DC,
      16'h003C, 16'h0012, 16'h0012, 16'h0001, 16'h0001, 16'h0004, 16'h0001,
      16'h0001};

   // Value after reset and after an initialisation
   localparam logic [DW-1:0] REG_DFLT [NREG] = '{
      16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h017C, 16'h000A, 16'h0000, 16'h0000,
      16'h0001, 16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000};

   // Suppression level range and default on the higher voltage class
   localparam logic [DW-1:0] OV_LEVEL_HI_MIN = 16'h0294;
   localparam logic [DW-1:0] OV_LEVEL_HI_MAX = 16'h030C;
   localparam logic [DW-1:0] OV_LEVEL_HI_DFLT = 16'h02F8;

   // Registers spared by a partial initialisation (communication settings)
   localparam logic [NREG-1:0] INIT_KEEP_MASK = 30'h0800_0000;

   // Scope code that resets everything
   localparam logic [DW-1:0] SCOPE_ALL = 16'h0000;
   // Trigger and protect codes
   localparam logic [DW-1:0] CODE_ON = 16'h0001;

   // Last startup count; startup spends one cycle more than this, then one init cycle, before the host may write (strap settling)
   localparam logic [1:0] STARTUP_CYCLES = 2'h3;

   // Phases of the bank control
   typedef enum logic [1:0] {PH_STARTUP, PH_RUN, PH_INIT} phase_t;

endpackage

// file: rtl/param_cell.sv
// One range-checked 16-bit parameter word.
// Assumes the owner supplies the current legal bounds and gates the write.
`timescale 1ns/1ps
`default_nettype none
module param_cell #(
   parameter logic [15:0] RST_VAL = 16'h0000
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_srst,
   // Initialisation load
   input wire logic i_load,
   input wire logic [15:0] i_load_val,
   // Host write and bounds
   input wire logic i_wr,
   input wire logic [15:0] i_wdata,
   input wire logic [15:0] i_lo,
   input wire logic [15:0] i_hi,
   // Stored word and range verdict
   output logic [15:0] o_value,
   output logic o_in_range
);

   logic [15:0] value_r; // Held parameter
   logic [15:0] value_nxt; // Next parameter

   // Bounds are inclusive at both ends
   assign o_in_range = (i_wdata >= i_lo) && (i_wdata <= i_hi);
   assign o_value = value_r;

   // Load wins over a write; an out-of-range write leaves the word alone
   always_comb
   begin
      value_nxt = value_r;
      if (i_load)
      begin
         value_nxt = i_load_val;
      end
      else if (i_wr && o_in_range)
      begin
         value_nxt = i_wdata;
      end
   end

   // Register only
   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
      begin
         value_r <= RST_VAL;
      end
      else
      begin
         value_r <= value_nxt;
      end
   end

endmodule
`default_nettype wire

// file: rtl/inverter_param_regs_b.sv
// Parameter bank for stop mode, carrier reduction, initialisation, the free
// V/f curve, over-voltage suppression, external panel and write protection.
// Assumes one 25 MHz clock, a synchronous reset and a never-waiting host port.
// Also assumes the class strap is steady for the first few cycles after reset.
`timescale 1ns/1ps
`default_nettype none
module inverter_param_regs_b (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_srst,
   // Host register port
   input wire logic [inverter_param_regs_b_pkg::AW-1:0] i_addr,
   input wire logic [inverter_param_regs_b_pkg::DW-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [inverter_param_regs_b_pkg::DW-1:0] o_rdata,
   output logic o_err,
   // Voltage class strap, high for the higher class
   input wire logic i_high_volt_class,
   // Settings toward the motor control
   output logic o_carrier_reduce_en,
   output logic o_stop_coast,
   output logic [1:0] o_ov_suppress_mode,
   output logic [2:0] o_link_loss_action,
   output logic o_write_protected,
   // Initialisation status
   output logic o_init_busy,
   output logic o_init_done
);
   import inverter_param_regs_b_pkg::*;

   // Strap synchroniser; only the second and third stages are compared
   // The first stage may go metastable, so nothing but stage two reads it
   // A later change of class is tracked but never rewrites a stored level
   logic cls_s1_r;
   logic cls_s2_r;
   logic cls_s3_r;
   logic cls_r; // Settled voltage class
   logic cls_nxt;

   // Bank control
   // Startup and initialisation share one phase register, so busy has a
   // single source and cannot glitch between two separate machines
   // The startup count is short on purpose: it only covers strap settling
   phase_t phase_r;
   phase_t phase_nxt;
   logic [1:0] cnt_r; // Startup settling count
   logic [1:0] cnt_nxt;
   logic full_r; // Pending initialisation covers every word
   logic full_nxt;
   logic done_r;
   logic done_nxt;

   // Host answer registers
   // Both return to zero outside the answer cycle, so a stale read never lingers
   // and a refusal is seen exactly once
   logic [DW-1:0] rdata_r;
   logic [DW-1:0] rdata_nxt;
   logic err_r;
   logic err_nxt;

   // Bank wiring
   // Bounds are recomputed every cycle from the live bank, not latched, so a
   // moved neighbour point takes effect on the very next write
   logic [DW-1:0] val [NREG]; // Stored words
   logic [DW-1:0] lo [NREG]; // Current lower bounds
   logic [DW-1:0] hi [NREG]; // Current upper bounds
   logic [DW-1:0] ld_val [NREG]; // Initialisation values
   logic [NREG-1:0] in_range; // Per-word verdict on i_wdata
   logic [NREG-1:0] sel; // Address decode
   logic [NREG-1:0] wr_go; // Write gate per word
   logic load_all; // Initialisation this cycle
   logic hit; // Address names a live word
   logic wr_ok; // Current write is stored

   // Three-stage strap capture; a new class counts once stages two and three agree
   // A one-cycle glitch on the pin never reaches stage three in agreement,
   // so it cannot flip the class
   always_comb
   begin
      cls_nxt = cls_r;
      if (cls_s2_r == cls_s3_r)
      begin
         cls_nxt = cls_s3_r;
      end
   end

   // Strap flops; reset reads the lower class until the chain has filled,
   // which the startup phase waits out before loading the level default
   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
      begin
         cls_s1_r <= 1'b0;
         cls_s2_r <= 1'b0;
         cls_s3_r <= 1'b0;
         cls_r <= 1'b0;
      end
      else
      begin
         cls_s1_r <= i_high_volt_class;
         cls_s2_r <= cls_s1_r;
         cls_s3_r <= cls_s2_r;
         cls_r <= cls_nxt;
      end
   end

   // Bounds and initialisation values for every word
   // The constant table is applied first, then the live exceptions below
   // override it: the moving caps of the curve and the class-dependent level
   // Keeping both in one process avoids two drivers on the same bound
   // The cap chain only reads flops, so no combinational loop forms
   always_comb
   begin
      for (int i = 0; i < NREG; i++)
      begin
         lo[i] = REG_MIN[i];
         hi[i] = REG_MAX[i];
         ld_val[i] = REG_DFLT[i];
      end
      // Each of the first six frequency points is capped by its successor
      for (int k = 0; k < 6; k++)
      begin
         hi[IDX_VF_F1 + 2 * k] = val[IDX_VF_F1 + 2 * k + 2];
      end
      // Suppression level range follows the voltage class
      if (cls_r)
      begin
         lo[IDX_OV_LEVEL] = OV_LEVEL_HI_MIN;
         hi[IDX_OV_LEVEL] = OV_LEVEL_HI_MAX;
         ld_val[IDX_OV_LEVEL] = OV_LEVEL_HI_DFLT;
      end
   end

   // Address decode; anything not in the table counts as inaccessible
   // Addresses in the table are unique, so at most one select is ever high
   // Reserved gaps inside the map and the unused span above it look alike
   always_comb
   begin
      for (int i = 0; i < NREG; i++)
      begin
         sel[i] = (i_addr == REG_ADDR[i]);
      end
   end

   assign hit = |sel;

   // A write lands only in run phase, on a live word, in range, and past protection
   // The protect word stays writable while set, otherwise the bank could
   // never be unlocked again without a reset
   // Writes during startup or an initialisation are refused, not queued
   // The range verdict comes from the selected cell only
   assign wr_ok = i_wr && hit && (phase_r == PH_RUN) && |(sel & in_range)
      && !((val[IDX_PROTECT] == CODE_ON) && !sel[IDX_PROTECT]);
   // Initialisation lasts exactly one cycle of the phase register
   // Every cell not spared by a partial scope loads its default then
   assign load_all = (phase_r == PH_INIT);

   // Per-word write gate; address decode keeps it one-hot
   // A refused write raises no gate at all
   always_comb
   begin
      for (int i = 0; i < NREG; i++)
      begin
         wr_go[i] = wr_ok && sel[i];
      end
   end

   // The bank itself
   // One cell per word; each checks its own bounds so the range logic repeats
   // Words spared by a partial initialisation keep their value, since their
   // load is masked while the pending scope is not the full one
   // Reset values equal the lower-class defaults; startup reloads them anyway
   genvar g;
   generate
      for (g = 0; g < NREG; g++)
      begin : g_cell
         param_cell #(
            .RST_VAL(REG_DFLT[g])
         ) u_cell (
            .i_clk_sys(i_clk_sys),
            .i_srst(i_srst),
            .i_load(load_all && (full_r || !INIT_KEEP_MASK[g])),
            .i_load_val(ld_val[g]),
            .i_wr(wr_go[g]),
            .i_wdata(i_wdata),
            .i_lo(lo[g]),
            .i_hi(hi[g]),
            .o_value(val[g]),
            .o_in_range(in_range[g])
         );
      end
   endgenerate

   // Phase control: settle the strap, load defaults, then serve the host
   // The scope is sampled at the trigger write, so a scope change in the
   // busy cycle cannot alter an initialisation already started
   always_comb
   begin
      phase_nxt = phase_r;
      cnt_nxt = cnt_r;
      full_nxt = full_r;
      done_nxt = 1'b0;
      unique case (phase_r)
         PH_STARTUP:
         begin
            // Waiting lets the class settle before its default level is loaded
            cnt_nxt = cnt_r + 2'h1;
            if (cnt_r == STARTUP_CYCLES)
            begin
               phase_nxt = PH_INIT;
               full_nxt = 1'b1;
            end
         end
         PH_RUN:
         begin
            // Writing one to the trigger starts an initialisation of the chosen scope
            // The trigger word itself is reloaded to zero by that initialisation
            if (wr_go[IDX_TRIGGER] && (i_wdata == CODE_ON))
            begin
               phase_nxt = PH_INIT;
               full_nxt = (val[IDX_SCOPE] == SCOPE_ALL);
            end
         end
         PH_INIT:
         begin
            // One cycle is enough: every cell loads in parallel
            phase_nxt = PH_RUN;
            done_nxt = 1'b1;
         end
         default:
         begin
            // The unused code restarts the bank rather than sticking
            phase_nxt = PH_STARTUP;
            cnt_nxt = 2'h0;
            full_nxt = 1'b1;
         end
      endcase
   end

   // Phase flops; reset starts a full startup initialisation every time,
   // so a mid-run reset also picks up a changed class strap
   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
      begin
         phase_r <= PH_STARTUP;
         cnt_r <= 2'h0;
         full_r <= 1'b1;
         done_r <= 1'b0;
      end
      else
      begin
         phase_r <= phase_nxt;
         cnt_r <= cnt_nxt;
         full_r <= full_nxt;
         done_r <= done_nxt;
      end
   end

   // Host answers: read data and refusal flag stand in the cycle after the strobe
   // Reads are served in every phase; a read during initialisation returns
   // the word as it stood before the load
   always_comb
   begin
      rdata_nxt = '0;
      err_nxt = 1'b0;
      if (i_rd)
      begin
         if (hit)
         begin
            for (int i = 0; i < NREG; i++)
            begin
               if (sel[i])
               begin
                  rdata_nxt = val[i];
               end
            end
         end
         else
         begin
            // Unmapped read: refuse, and the data stays zero
            err_nxt = 1'b1;
         end
      end
      else if (i_wr && !wr_ok)
      begin
         // Any write that was not stored is reported, whatever the reason, unless a read is strobed in the same cycle
         err_nxt = 1'b1;
      end
   end

   // Answer flops; registering them keeps the host timing independent of
   // the depth of the read multiplexer
   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
      begin
         rdata_r <= '0;
         err_r <= 1'b0;
      end
      else
      begin
         rdata_r <= rdata_nxt;
         err_r <= err_nxt;
      end
   end

   // Outputs; settings come straight from the bank flops
   // Only the low bits that carry a legal code are passed on; the range
   // check guarantees the upper bits of these words are zero
   // Busy is a decode of the phase register and is therefore glitch-free
   assign o_rdata = rdata_r;
   assign o_err = err_r;
   assign o_carrier_reduce_en = val[IDX_CARRIER][0];
   assign o_stop_coast = val[IDX_STOP][0];
   assign o_ov_suppress_mode = val[IDX_OV_EN][1:0];
   assign o_link_loss_action = val[IDX_LINK_LOSS][2:0];
   assign o_write_protected = val[IDX_PROTECT][0];
   assign o_init_busy = (phase_r != PH_RUN);
   assign o_init_done = done_r;

endmodule
`default_nettype wire

// file: dv/inverter_param_regs_b_checker.sv
// Assertions on the parameter bank ports.
// Assumes it is bound to the bank top and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module inverter_param_regs_b_checker (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_srst,
   // Host port
   input wire logic [15:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [15:0] o_rdata,
   input wire logic o_err,
   // Strap and settings
   input wire logic i_high_volt_class,
   input wire logic o_carrier_reduce_en,
   input wire logic o_stop_coast,
   input wire logic [1:0] o_ov_suppress_mode,
   input wire logic [2:0] o_link_loss_action,
   input wire logic o_write_protected,
   input wire logic o_init_busy,
   input wire logic o_init_done
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_srst);
   // A write the bank must take when in range
   wire logic open_wr = i_wr && !o_init_busy && !o_write_protected;
   rdata_quiet_a:
      assert property (!i_rd |=> o_rdata == 16'h0) else $error("read data not idle");
   hole_read_a:
      assert property (i_rd && (i_addr == 16'h135D || i_addr == 16'h13B8)
         |=> o_err && o_rdata == 16'h0) else $error("reserved read not refused");
   wide_value_a:
      assert property (i_wr && i_addr == 16'h13B7 && i_wdata > 16'h1 |=> o_err)
      else $error("out of range write accepted");
   stop_update_a:
      assert property (open_wr && i_addr == 16'h135E && i_wdata <= 16'h1
         |=> !o_err && o_stop_coast == $past(i_wdata[0])) else $error("stop method not stored");
   carrier_update_a:
      assert property (open_wr && i_addr == 16'h135C && i_wdata <= 16'h1
         |=> o_carrier_reduce_en == $past(i_wdata[0])) else $error("carrier flag not stored");
   ov_mode_a:
      assert property (open_wr && i_addr == 16'h1385 && i_wdata <= 16'h3
         |=> o_ov_suppress_mode == $past(i_wdata[1:0])) else $error("suppress mode not stored");
   loss_refuse_a:
      assert property (i_wr && i_addr == 16'h13A8 && i_wdata > 16'h4
         |=> o_err && $stable(o_link_loss_action)) else $error("bad loss code accepted");
   protect_hold_a:
      assert property (o_write_protected && i_wr && i_addr != 16'h13A9 |=> o_err)
      else $error("protected write accepted");
   init_end_a:
      assert property ($fell(o_init_busy) |-> o_init_done ##1 !o_init_done)
      else $error("init done pulse wrong");
   cover property (o_init_done);
   cover property (i_rd ##1 o_err);
   cover property (o_write_protected && i_wr);
endmodule
bind inverter_param_regs_b inverter_param_regs_b_checker u_chk (.i_clk_sys, .i_srst, .i_addr,
   .i_wdata, .i_wr, .i_rd, .o_rdata, .o_err, .i_high_volt_class, .o_carrier_reduce_en,
   .o_stop_coast, .o_ov_suppress_mode, .o_link_loss_action, .o_write_protected, .o_init_busy,
   .o_init_done);
`default_nettype wire

// file: dv/host_port_model.sv
// Host model issuing one-cycle register reads and writes.
// Assumes the bank answers next cycle and never stalls.
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
   // Clock
   input wire logic i_clk_sys,
   // Port toward the bank
   output logic [15:0] o_addr,
   output logic [15:0] o_wdata,
   output logic o_wr,
   output logic o_rd
);
   // Idle at time zero
   initial
   begin
      o_addr = 16'h0;
      o_wdata = 16'h0;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end
   // Released address and data lines show the inverse so a stale value never passes; strobes drop to zero
   task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
      @(posedge i_clk_sys);
      o_wr <= w;
      o_rd <= !w;
      o_addr <= a;
      o_wdata <= d;
      @(posedge i_clk_sys);
      o_wr <= 1'b0;
      o_rd <= 1'b0;
      o_addr <= ~a;
      o_wdata <= ~d;
   endtask
endmodule
`default_nettype wire

// file: dv/inverter_param_regs_b_tb_top.sv
// Bench for the parameter bank: map, ranges, protection, init.
// Assumes the host model drives the port; bounds come from the package.
`timescale 1ns/1ps
`default_nettype none
module inverter_param_regs_b_tb_top;
   import inverter_param_regs_b_pkg::*;
   logic i_clk_sys, i_srst, i_high_volt_class, i_wr, i_rd, o_err, o_carrier_reduce_en;
   logic o_stop_coast, o_write_protected, o_init_busy, o_init_done;
   logic [15:0] i_addr, i_wdata, o_rdata;
   logic [1:0] o_ov_suppress_mode;
   logic [2:0] o_link_loss_action;
   int n_mismatch, total_checks;
   // Reserved and unused holes
   logic [15:0] holes [4] = '{16'h135D, 16'h1360, 16'h13B8, 16'h1400};
   host_port_model u_host (.i_clk_sys, .o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr),
      .o_rd(i_rd));
   inverter_param_regs_b dut (.i_clk_sys, .i_srst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
      .o_err, .i_high_volt_class, .o_carrier_reduce_en, .o_stop_coast, .o_ov_suppress_mode,
      .o_link_loss_action, .o_write_protected, .o_init_busy, .o_init_done);
   // 25 MHz clock
   initial
   begin
      i_clk_sys = 1'b0;
      forever #20 i_clk_sys = ~i_clk_sys;
   end
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Answer is sampled in the cycle after the strobe
   task automatic wr_chk(input logic [15:0] a, input logic [15:0] d, input logic e);
      u_host.acc(1'b1, a, d);
      #1;
      chk("write error", {15'h0, o_err}, {15'h0, e});
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic [15:0] d, input logic e);
      u_host.acc(1'b0, a, 16'h0);
      #1;
      chk("read data", o_rdata, d);
      chk("read error", {15'h0, o_err}, {15'h0, e});
   endtask
   task automatic do_reset(input logic cls);
      int k;
      @(posedge i_clk_sys);
      i_srst <= 1'b1;
      i_high_volt_class <= cls;
      repeat (20) @(posedge i_clk_sys);
      i_srst <= 1'b0;
      k = 0;
      while (o_init_busy !== 1'b0 && k < 50)
      begin
         @(posedge i_clk_sys);
         #1;
         k++;
      end
      chk("startup busy", {15'h0, o_init_busy}, 16'h0);
   endtask
   // Trigger, then busy for one cycle and a one-cycle done
   task automatic init_run;
      wr_chk(16'h13B7, 16'h1, 1'b0);
      chk("busy", {15'h0, o_init_busy}, 16'h1);
      @(posedge i_clk_sys);
      #1;
      chk("busy end", {15'h0, o_init_busy}, 16'h0);
      chk("done", {15'h0, o_init_done}, 16'h1);
      @(posedge i_clk_sys);
      #1;
      chk("done end", {15'h0, o_init_done}, 16'h0);
      rd_chk(16'h13B7, 16'h0, 1'b0);
   endtask
   // Hang guard, far beyond the few hundred cycles used
   initial
   begin
      #800000;
      n_mismatch++;
      finish_test();
   end
   initial
   begin
      i_srst = 1'b1;
      i_high_volt_class = 1'b0;
      n_mismatch = 0;
      total_checks = 0;
      do_reset(1'b0);
      for (int i = 0; i < NREG; i++)
         rd_chk(REG_ADDR[i], REG_DFLT[i], 1'b0);
      $display("test defaults done");
      // Frequency points 1 to 6 have moving caps; only points 5 and 6 are tested apart
      for (int i = 0; i < NREG; i++)
         if (i != IDX_PROTECT && i != IDX_TRIGGER && !(i >= IDX_VF_F1 && i < IDX_VF_F7 && i % 2))
         begin
            wr_chk(REG_ADDR[i], REG_MAX[i], 1'b0);
            wr_chk(REG_ADDR[i], REG_MAX[i] + 16'h1, 1'b1);
            if (REG_MIN[i] != 16'h0)
               wr_chk(REG_ADDR[i], REG_MIN[i] - 16'h1, 1'b1);
            rd_chk(REG_ADDR[i], REG_MAX[i], 1'b0);
         end
      chk("carrier", {15'h0, o_carrier_reduce_en}, 16'h1);
      chk("stop", {15'h0, o_stop_coast}, 16'h1);
      for (int c = 0; c < 5; c++)
      begin
         wr_chk(16'h13A8, 16'(c), 1'b0);
         chk("loss", {13'h0, o_link_loss_action}, 16'(c));
         wr_chk(16'h1385, 16'(c), c > 3);
         chk("ov mode", {14'h0, o_ov_suppress_mode}, 16'(c > 3 ? 3 : c));
      end
      wr_chk(16'h1371, 16'h0064, 1'b0);
      wr_chk(16'h136F, 16'h0065, 1'b1);
      wr_chk(16'h136F, 16'h0064, 1'b0);
      wr_chk(16'h13B7, 16'h0002, 1'b1);
      rd_chk(16'h13B7, 16'h0000, 1'b0);
      $display("test ranges done");
      foreach (holes[j])
      begin
         rd_chk(holes[j], 16'h0, 1'b1);
         wr_chk(holes[j], 16'h1, 1'b1);
      end
      wr_chk(16'h13A9, 16'h1, 1'b0);
      chk("protect", {15'h0, o_write_protected}, 16'h1);
      wr_chk(16'h135E, 16'h0, 1'b1);
      rd_chk(16'h135E, 16'h1, 1'b0);
      wr_chk(16'h13A9, 16'h0, 1'b0);
      $display("test access done");
      init_run();
      rd_chk(16'h13A8, 16'h4, 1'b0);
      rd_chk(16'h135E, 16'h0, 1'b0);
      wr_chk(16'h13A8, 16'h2, 1'b0);
      init_run();
      rd_chk(16'h13A8, 16'h0, 1'b0);
      $display("test init done");
      do_reset(1'b1);
      rd_chk(16'h1386, OV_LEVEL_HI_DFLT, 1'b0);
      wr_chk(16'h1386, OV_LEVEL_HI_MIN - 16'h1, 1'b1);
      wr_chk(16'h1386, OV_LEVEL_HI_MAX, 1'b0);
      wr_chk(16'h1386, OV_LEVEL_HI_MAX + 16'h1, 1'b1);
      $display("test high class done");
      finish_test();
   end
endmodule
`default_nettype wire
